// file: rtl/fbds_map.svh
// Register indices, field positions, divide ratios and monitor codes of the
// feedback divider and monitor select block.
// Assumes the APB byte address is four times the register index.
`ifndef FBDS_MAP_SVH
`define FBDS_MAP_SVH

`define FBDS_IDX_FB_CTRL   8'h16
`define FBDS_IDX_MON_SEL   8'h17
`define FBDS_IDX_SW_VAL    8'h20
`define FBDS_IDX_MAIN_VAL  8'h21
`define FBDS_IDX_REF_VAL   8'h22
`define FBDS_IDX_REF_CFG   8'h23
`define FBDS_IDX_STATUS    8'h24

`define FBDS_RST_BYTE      8'h00
`define FBDS_BIT_REF_RST   6
`define FBDS_BIT_AB_RST    5
`define FBDS_BIT_ALL_RST   4
`define FBDS_BIT_BYPASS    3
`define FBDS_PRE_MSB       2
`define FBDS_MON_MSB       7
`define FBDS_MON_LSB       2
`define FBDS_MON_TOP       5
`define FBDS_CFG_DIFF      0
`define FBDS_CFG_PICK2     1

`define FBDS_PRE_FD1       3'h0
`define FBDS_PRE_FD2       3'h1
`define FBDS_PRE_DM3       3'h2
`define FBDS_PRE_DM5       3'h3
`define FBDS_PRE_DM9       3'h4
`define FBDS_PRE_DM17      3'h5
`define FBDS_PRE_DM33      3'h6
`define FBDS_PRE_FD3       3'h7

`define FBDS_DIV1          6'h01
`define FBDS_DIV2          6'h02
`define FBDS_DIV3          6'h03
`define FBDS_DIV4          6'h04
`define FBDS_DIV8          6'h08
`define FBDS_DIV16         6'h10
`define FBDS_DIV32         6'h20
`define FBDS_DM_EXTRA      6'h01
`define FBDS_MAIN_ONE      13'h0001
`define FBDS_SW_ONE        6'h01

`define FBDS_MON_GND       6'h00
`define FBDS_MON_N         6'h01
`define FBDS_MON_R         6'h02
`define FBDS_MON_A         6'h03
`define FBDS_MON_PRE       6'h04
`define FBDS_MON_UP        6'h05
`define FBDS_MON_DN        6'h06
`define FBDS_MON_RM_GND    6'h20
`define FBDS_MON_RM_FIRST_REFERENCE_INPUT   6'h21
`define FBDS_MON_RM_SECOND_REFERENCE_INPUT   6'h22

`endif

// file: rtl/fbds_pkg.sv
// Types shared by the feedback divider and monitor select block.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package fbds_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fbds_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fbds_apb_rsp_t;

  typedef struct packed {
    logic vco;
    logic first_reference_input;
    logic second_reference_input;
    logic ref_diff;
    logic pfd_up;
    logic pfd_dn;
  } fbds_pins_t;

  typedef enum logic {
    FBDS_FIXED,
    FBDS_DUAL
  } fbds_pre_mode_t;

endpackage

// file: rtl/fbds_sync2.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to i_sys_clk.
`timescale 1ns/10ps
module fbds_sync2 #(
  parameter int W = 6
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fbds_sync_st_t;

  fbds_sync_st_t st_r;
  fbds_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_clk_en) begin
      st_nxt.s1 = i_async;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;
endmodule

// file: rtl/fbds_div_cnt.sv
// Programmable event divider: counts steps and flags the last of each group.
// Assumes steps and clear come from logic on i_sys_clk; ratio 0 acts as 1.
`timescale 1ns/10ps
module fbds_div_cnt #(
  parameter int W = 6
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  input  wire logic         i_clr,
  input  wire logic         i_step,
  input  wire logic [W-1:0] i_ratio,
  output logic              o_tc,
  output logic      [W-1:0] o_cnt
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } fbds_cnt_st_t;

  fbds_cnt_st_t st_r;
  fbds_cnt_st_t st_nxt;
  logic [W-1:0] last;

  // A ratio lowered mid-count still ends the group at the next step
  always_comb begin
    last   = ((i_ratio == '0) ? W'(1) : i_ratio) - W'(1);
    o_tc   = i_step && !i_clr && (st_r.cnt >= last);
    st_nxt = st_r;
    if (i_clk_en) begin
      if (i_clr) begin
        st_nxt.cnt = '0;
      end else if (o_tc) begin
        st_nxt.cnt = '0;
      end else if (i_step) begin
        st_nxt.cnt = st_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cnt = st_r.cnt;
endmodule

// file: rtl/fbds_top.sv
// Feedback divider (prescaler, swallow and main counters), reference
// divider and monitor pin select, with an APB register slave.
// Assumes VCO, reference and phase detector levels arrive as pins slower
// than half of i_sys_clk; each is synchronised before use.
`timescale 1ns/10ps
`include "fbds_map.svh"

module fbds_top (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_clk_en,
  input  wire fbds_pkg::fbds_apb_req_t i_apb,
  output fbds_pkg::fbds_apb_rsp_t     o_apb,
  input  wire fbds_pkg::fbds_pins_t    i_pins,
  output logic                        o_monitor_pin
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           fb_ctrl;
    logic [7:0]           mon_sel;
    logic [5:0]           sw_val;
    logic [12:0]          main_val;
    logic [13:0]          ref_val;
    logic [1:0]           ref_cfg;
    fbds_pkg::fbds_pins_t pins_prev;
    logic [5:0]           sw_left;
    logic                 n_out;
    logic                 r_out;
    logic                 a_out;
    logic                 pre_out;
    logic                 mon;
    logic [31:0]          prdata;
    logic                 pslverr;
  } fbds_top_st_t;

  fbds_top_st_t             st_r;
  fbds_top_st_t             st_nxt;
  fbds_pkg::fbds_pins_t     pins_s;
  fbds_pkg::fbds_pre_mode_t pre_mode;
  logic [2:0]               pre_code;
  logic [5:0]               mon_code;
  logic [5:0]               pre_ratio;
  logic [12:0]              main_ratio;
  logic                     sw_nz;
  logic                     bypass_eff;
  logic                     ab_clr;
  logic                     ref_clr;
  logic                     vco_rise;
  logic                     ref_now;
  logic                     ref_prev;
  logic                     ref_rise;
  logic                     pre_tc;
  logic                     main_tc;
  logic                     ref_tc;
  logic                     a_evt;
  logic [12:0]              main_cnt;
  logic [13:0]              ref_cnt;
  logic                     apb_setup;
  logic                     apb_access;
  logic [7:0]               apb_idx;
  logic                     apb_bad;
  logic [31:0]              rd_word;
  logic                     rd_hit;

  // ----------------------------------------------------------------------
  // Pin synchronisers and dividers
  // ----------------------------------------------------------------------
  fbds_sync2 #(.W(6)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_async   (i_pins),
    .o_sync    (pins_s)
  );

  fbds_div_cnt #(.W(6)) u_prescaler (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_clr     (ab_clr),
    .i_step    (vco_rise),
    .i_ratio   (pre_ratio),
    .o_tc      (pre_tc),
    .o_cnt     ()
  );

  fbds_div_cnt #(.W(13)) u_main (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_clr     (ab_clr),
    .i_step    (pre_tc),
    .i_ratio   (main_ratio),
    .o_tc      (main_tc),
    .o_cnt     (main_cnt)
  );

  fbds_div_cnt #(.W(14)) u_ref (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_clr     (ref_clr),
    .i_step    (ref_rise),
    .i_ratio   (st_r.ref_val),
    .o_tc      (ref_tc),
    .o_cnt     (ref_cnt)
  );

  // ----------------------------------------------------------------------
  // Divider control
  // ----------------------------------------------------------------------
  always_comb begin
    pre_code = st_r.fb_ctrl[`FBDS_PRE_MSB:0];
    mon_code = st_r.mon_sel[`FBDS_MON_MSB:`FBDS_MON_LSB];
    sw_nz    = (st_r.sw_left != '0);
    ab_clr   = st_r.fb_ctrl[`FBDS_BIT_AB_RST] || st_r.fb_ctrl[`FBDS_BIT_ALL_RST];
    ref_clr  = st_r.fb_ctrl[`FBDS_BIT_REF_RST] || st_r.fb_ctrl[`FBDS_BIT_ALL_RST];
    vco_rise = pins_s.vco && !st_r.pins_prev.vco;
    if (st_r.ref_cfg[`FBDS_CFG_DIFF]) begin
      ref_now  = pins_s.ref_diff;
      ref_prev = st_r.pins_prev.ref_diff;
    end else if (st_r.ref_cfg[`FBDS_CFG_PICK2]) begin
      ref_now  = pins_s.second_reference_input;
      ref_prev = st_r.pins_prev.second_reference_input;
    end else begin
      ref_now  = pins_s.first_reference_input;
      ref_prev = st_r.pins_prev.first_reference_input;
    end
    ref_rise = ref_now && !ref_prev;
    pre_mode = fbds_pkg::FBDS_DUAL;
    unique case (pre_code)
      `FBDS_PRE_FD1: begin
        pre_mode  = fbds_pkg::FBDS_FIXED;
        pre_ratio = `FBDS_DIV1;
      end
      `FBDS_PRE_FD2: begin
        pre_mode  = fbds_pkg::FBDS_FIXED;
        pre_ratio = `FBDS_DIV2;
      end
      `FBDS_PRE_FD3: begin
        pre_mode  = fbds_pkg::FBDS_FIXED;
        pre_ratio = `FBDS_DIV3;
      end
      `FBDS_PRE_DM3:  pre_ratio = `FBDS_DIV2 + (sw_nz ? `FBDS_DM_EXTRA : '0);
      `FBDS_PRE_DM5:  pre_ratio = `FBDS_DIV4 + (sw_nz ? `FBDS_DM_EXTRA : '0);
      `FBDS_PRE_DM9:  pre_ratio = `FBDS_DIV8 + (sw_nz ? `FBDS_DM_EXTRA : '0);
      `FBDS_PRE_DM17: pre_ratio = `FBDS_DIV16 + (sw_nz ? `FBDS_DM_EXTRA : '0);
      `FBDS_PRE_DM33: pre_ratio = `FBDS_DIV32 + (sw_nz ? `FBDS_DM_EXTRA : '0);
    endcase
    bypass_eff = st_r.fb_ctrl[`FBDS_BIT_BYPASS] && (pre_mode == fbds_pkg::FBDS_FIXED);
    main_ratio = bypass_eff ? `FBDS_MAIN_ONE : st_r.main_val;
    // Swallow output pulses when the count runs out inside a cycle
    a_evt = pre_tc && (st_r.sw_left == `FBDS_SW_ONE) && !main_tc;
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  always_comb begin
    apb_setup  = i_apb.psel && !i_apb.penable;
    apb_access = i_apb.psel && i_apb.penable && i_clk_en;
    apb_idx    = i_apb.paddr[9:2];
    rd_hit     = 1'b1;
    rd_word    = '0;
    unique case (apb_idx)
      `FBDS_IDX_FB_CTRL:  rd_word[7:0]  = st_r.fb_ctrl;
      `FBDS_IDX_MON_SEL:  rd_word[7:0]  = st_r.mon_sel;
      `FBDS_IDX_SW_VAL:   rd_word[5:0]  = st_r.sw_val;
      `FBDS_IDX_MAIN_VAL: rd_word[12:0] = st_r.main_val;
      `FBDS_IDX_REF_VAL:  rd_word[13:0] = st_r.ref_val;
      `FBDS_IDX_REF_CFG:  rd_word[1:0]  = st_r.ref_cfg;
      `FBDS_IDX_STATUS:   rd_word[13:0] = {st_r.sw_left, 2'h0, (pre_mode == fbds_pkg::FBDS_DUAL),
                                           st_r.mon, st_r.pre_out, st_r.a_out,
                                           st_r.r_out, st_r.n_out};
      default:            rd_hit        = 1'b0;
    endcase
    // Read-only status, stray high address bits and byte offsets are errors
    apb_bad = !rd_hit || (i_apb.paddr[11:10] != 2'h0) || (i_apb.paddr[1:0] != 2'h0) ||
              (i_apb.pwrite && (apb_idx == `FBDS_IDX_STATUS));
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (i_clk_en) begin
      st_nxt.pins_prev = pins_s;
      if (apb_setup) begin
        st_nxt.prdata  = i_apb.pwrite ? '0 : (apb_bad ? '0 : rd_word);
        st_nxt.pslverr = apb_bad;
      end
      if (apb_access && i_apb.pwrite && !st_r.pslverr) begin
        unique case (apb_idx)
          `FBDS_IDX_FB_CTRL:  st_nxt.fb_ctrl  = i_apb.pwdata[7:0];
          `FBDS_IDX_MON_SEL:  st_nxt.mon_sel  = i_apb.pwdata[7:0];
          `FBDS_IDX_SW_VAL:   st_nxt.sw_val   = i_apb.pwdata[5:0];
          `FBDS_IDX_MAIN_VAL: st_nxt.main_val = i_apb.pwdata[12:0];
          `FBDS_IDX_REF_VAL:  st_nxt.ref_val  = i_apb.pwdata[13:0];
          `FBDS_IDX_REF_CFG:  st_nxt.ref_cfg  = i_apb.pwdata[1:0];
          default: ;
        endcase
      end
      // Swallow count restarts with each feedback cycle
      if (ab_clr || main_tc) begin
        st_nxt.sw_left = st_r.sw_val;
      end else if (pre_tc && sw_nz) begin
        st_nxt.sw_left = st_r.sw_left - `FBDS_SW_ONE;
      end
      st_nxt.n_out   = main_tc;
      st_nxt.r_out   = ref_tc;
      st_nxt.a_out   = a_evt;
      st_nxt.pre_out = pre_tc;
      case (mon_code)
        `FBDS_MON_N:       st_nxt.mon = st_r.n_out;
        `FBDS_MON_A:       st_nxt.mon = st_r.a_out;
        `FBDS_MON_PRE:     st_nxt.mon = st_r.pre_out;
        `FBDS_MON_R:       st_nxt.mon = st_r.r_out;
        `FBDS_MON_UP:      st_nxt.mon = pins_s.pfd_up;
        `FBDS_MON_DN:      st_nxt.mon = pins_s.pfd_dn;
        `FBDS_MON_RM_FIRST_REFERENCE_INPUT: st_nxt.mon = st_r.ref_cfg[`FBDS_CFG_DIFF] ?
                                        pins_s.ref_diff : pins_s.first_reference_input;
        `FBDS_MON_RM_SECOND_REFERENCE_INPUT: st_nxt.mon = !st_r.ref_cfg[`FBDS_CFG_DIFF] && pins_s.second_reference_input;
        default:           st_nxt.mon = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r         <= '0;
      st_r.fb_ctrl <= `FBDS_RST_BYTE;
      st_r.mon_sel <= `FBDS_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_apb.pready  = i_apb.psel && i_apb.penable && i_clk_en;
  assign o_apb.prdata  = st_r.prdata;
  assign o_apb.pslverr = st_r.pslverr && o_apb.pready;
  assign o_monitor_pin = st_r.mon;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_fd_bypass_tick;
    i_clk_en && bypass_eff && pre_tc && !ab_clr;
  endsequence

  property p_mon_path(logic [5:0] code, logic src);
    (i_clk_en && mon_code == code) |=> (o_monitor_pin == $past(src));
  endproperty

  a_bypass_dm_ignored: assert property ((pre_mode == fbds_pkg::FBDS_DUAL)
    |-> (main_ratio == st_r.main_val)) else $error("bypass acted in dual modulus mode");
  a_bypass_div_one: assert property (s_fd_bypass_tick |=> st_r.n_out ##1
    (o_monitor_pin || !$past(i_clk_en) || ($past(mon_code) != `FBDS_MON_N)))
    else $error("bypassed main counter missed");
  a_pre_dm3: assert property ((pre_code == `FBDS_PRE_DM3) |->
    (pre_ratio == (sw_nz ? `FBDS_DIV3 : `FBDS_DIV2))) else $error("prescaler 3/2 wrong");
  a_pre_dm5_9: assert property ((pre_code inside {`FBDS_PRE_DM5, `FBDS_PRE_DM9}) |->
    (pre_ratio == ((pre_code == `FBDS_PRE_DM5 ? `FBDS_DIV4 : `FBDS_DIV8) +
     (sw_nz ? `FBDS_DM_EXTRA : 6'h00)))) else $error("prescaler 5/4 or 9/8 wrong");
  a_pre_dm17_33: assert property ((pre_code inside {`FBDS_PRE_DM17, `FBDS_PRE_DM33}) |->
    (pre_ratio == ((pre_code == `FBDS_PRE_DM17 ? `FBDS_DIV16 : `FBDS_DIV32) +
     (sw_nz ? `FBDS_DM_EXTRA : 6'h00)))) else $error("prescaler 17/16 or 33/32 wrong");
  a_pre_fixed: assert property ((pre_mode == fbds_pkg::FBDS_FIXED) |->
    (pre_ratio == (pre_code == `FBDS_PRE_FD1 ? `FBDS_DIV1 :
     (pre_code == `FBDS_PRE_FD2 ? `FBDS_DIV2 : `FBDS_DIV3)))) else $error("fixed ratio wrong");
  a_mon_n_path: assert property (p_mon_path(`FBDS_MON_N, st_r.n_out))
    else $error("monitor not showing feedback output");
  a_mon_a_path: assert property (p_mon_path(`FBDS_MON_A, st_r.a_out))
    else $error("monitor not showing swallow output");
  a_mon_r_path: assert property (p_mon_path(`FBDS_MON_R, st_r.r_out))
    else $error("monitor not showing reference divider");
  a_mon_up_path: assert property (p_mon_path(`FBDS_MON_UP, pins_s.pfd_up))
    else $error("monitor not showing up pulse");
  a_mon_low_half: assert property ((i_clk_en && !mon_code[`FBDS_MON_TOP] &&
    (mon_code == `FBDS_MON_GND || mon_code > `FBDS_MON_DN)) |=> !o_monitor_pin)
    else $error("monitor not grounded");
  a_mon_rm_gnd: assert property ((i_clk_en && mon_code == `FBDS_MON_RM_GND)
    |=> !o_monitor_pin [*2] or (mon_code != `FBDS_MON_RM_GND))
    else $error("reference monitor ground not low");
  a_mon_first_reference_input: assert property ((i_clk_en && mon_code == `FBDS_MON_RM_FIRST_REFERENCE_INPUT) |=>
    (o_monitor_pin == $past(st_r.ref_cfg[`FBDS_CFG_DIFF] ? pins_s.ref_diff : pins_s.first_reference_input)))
    else $error("monitor not showing first reference");
  a_mon_second_reference_input_diff: assert property ((i_clk_en && mon_code == `FBDS_MON_RM_SECOND_REFERENCE_INPUT &&
    st_r.ref_cfg[`FBDS_CFG_DIFF]) |=> !o_monitor_pin) else $error("second reference in diff");
  a_ref_hold: assert property ((i_clk_en && st_r.fb_ctrl[`FBDS_BIT_REF_RST]) |=>
    (ref_cnt == 14'h0000) && !st_r.r_out) else $error("reference divider not held");
  a_all_reset: assert property ((i_clk_en && st_r.fb_ctrl[`FBDS_BIT_ALL_RST]) |=>
    (ref_cnt == 14'h0000) && (main_cnt == 13'h0000) && (st_r.sw_left == $past(st_r.sw_val)))
    else $error("counters not reset together");

  // ----------------------------------------------------------------------
  // Bus, clock enable, swallow and prescaler mode checks
  // ----------------------------------------------------------------------
  sequence s_refused_write;
    apb_access && i_apb.pwrite && st_r.pslverr;
  endsequence

  sequence s_bad_setup;
    i_clk_en && apb_setup && apb_bad;
  endsequence

  sequence s_swallow_step;
    i_clk_en && pre_tc && sw_nz && !ab_clr && !main_tc;
  endsequence

  sequence s_cycle_end;
    i_clk_en && main_tc;
  endsequence

  a_err_no_write: assert property (s_refused_write |=> $stable(st_r.fb_ctrl) &&
    $stable(st_r.mon_sel) && $stable(st_r.sw_val) && $stable(st_r.ref_cfg))
    else $error("refused write changed a register");
  a_err_read_zero: assert property (s_bad_setup |=> (o_apb.prdata == '0) &&
    st_r.pslverr) else $error("refused read returned data");
  a_freeze_state: assert property (!i_clk_en |=> $stable(st_r) && $stable(main_cnt) &&
    $stable(ref_cnt)) else $error("state moved with clock enable low");
  a_swallow_step: assert property (s_swallow_step |=>
    (st_r.sw_left == $past(st_r.sw_left) - `FBDS_SW_ONE)) else $error("swallow count stuck");
  a_swallow_reload: assert property (s_cycle_end |=>
    (st_r.sw_left == $past(st_r.sw_val))) else $error("swallow count not reloaded");
  a_dm_mode_flag: assert property ((pre_code inside {`FBDS_PRE_FD1, `FBDS_PRE_FD2,
    `FBDS_PRE_FD3}) == (pre_mode == fbds_pkg::FBDS_FIXED)) else $error("prescaler mode wrong");
endmodule

// file: tb/fbds_board.sv
// Board model beside the monitor pin: drives pin levels, counts monitor pulses.
// Assumes its tasks are called from the bench in step with i_sys_clk.
`timescale 1ns/10ps
module fbds_board (
  input  wire logic            i_sys_clk,
  input  wire logic            i_monitor,
  output fbds_pkg::fbds_pins_t o_pins
);
  int unsigned mon_edges;
  logic        mon_q;

  initial begin
    o_pins    = '0;
    mon_edges = 0;
    mon_q     = 1'b0;
  end

  // ------------------------------------------------------------
  // Monitor pulse count
  // ------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_monitor === 1'b1 && mon_q !== 1'b1) begin
      mon_edges <= mon_edges + 1;
    end
    mon_q <= i_monitor;
  end

  // Cleared off the rising edge so it never races the count
  task automatic clear();
    @(negedge i_sys_clk);
    mon_edges = 0;
  endtask

  // ------------------------------------------------------------
  // Pin drive: three cycles high, three low, well above sync needs
  // ------------------------------------------------------------
  task automatic toggle(input fbds_pkg::fbds_pins_t mask, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge i_sys_clk);
      o_pins <= o_pins | mask;
      repeat (3) @(posedge i_sys_clk);
      o_pins <= o_pins & ~mask;
    end
  endtask

  task automatic set_lvl(input fbds_pkg::fbds_pins_t v);
    @(posedge i_sys_clk);
    o_pins <= v;
  endtask
endmodule

// file: tb/test_feedback_divider_status_select.sv
// Self-checking bench for the feedback divider and monitor select block.
// Assumes fbds_top with zero-wait APB and the board model on its pins.
`timescale 1ns/10ps
`include "fbds_map.svh"
module test_feedback_divider_status_select;
  logic                    i_sys_clk;
  logic                    i_rst_n;
  logic                    i_clk_en;
  fbds_pkg::fbds_apb_req_t i_apb;
  fbds_pkg::fbds_apb_rsp_t o_apb;
  fbds_pkg::fbds_pins_t    pins;
  logic                    o_monitor_pin;
  logic [31:0]             rd;
  logic                    er;
  int                      err_total;
  int                      n_compared;

  fbds_top DUT (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_clk_en      (i_clk_en),
    .i_apb         (i_apb),
    .o_apb         (o_apb),
    .i_pins        (pins),
    .o_monitor_pin (o_monitor_pin)
  );

  fbds_board board (
    .i_sys_clk (i_sys_clk),
    .i_monitor (o_monitor_pin),
    .o_pins    (pins)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // ------------------------------------------------------------
  // Compare, bus cycle and verdict
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    i_apb <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, d};
    @(posedge i_sys_clk);
    i_apb.penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_apb.pready !== 1'b1);
    chk("wait states", k, 32'h1);
    rd = o_apb.prdata;
    er = o_apb.pslverr;
    i_apb.psel    <= 1'b0;
    i_apb.penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Counters held in reset, then released and clocked 130 times
  task automatic div(input logic [7:0] ctl, input logic [5:0] sw, input logic [5:0] sel,
                     input logic [5:0] mask, input int n);
    apb(1'b1, `FBDS_IDX_SW_VAL, {26'h0, sw});
    apb(1'b1, `FBDS_IDX_FB_CTRL, {24'h0, ctl | 8'h10});
    apb(1'b1, `FBDS_IDX_MON_SEL, {24'h0, sel, 2'h0});
    apb(1'b1, `FBDS_IDX_FB_CTRL, {24'h0, ctl});
    board.clear();
    board.toggle(fbds_pkg::fbds_pins_t'(mask), 130);
    repeat (10) @(posedge i_sys_clk);
    chk("monitor pulses", board.mon_edges, n);
  endtask

  task automatic lvl(input logic [5:0] sel, input logic cfg, input logic [5:0] p, input logic e);
    apb(1'b1, `FBDS_IDX_REF_CFG, {31'h0, cfg});
    apb(1'b1, `FBDS_IDX_MON_SEL, {24'h0, sel, 2'h0});
    board.set_lvl(fbds_pkg::fbds_pins_t'(p));
    repeat (8) @(posedge i_sys_clk);
    chk("monitor level", {31'h0, o_monitor_pin}, {31'h0, e});
  endtask

  initial begin
    repeat (40000) @(posedge i_sys_clk);
    err_total++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    i_rst_n    = 1'b0;
    i_clk_en   = 1'b1;
    i_apb      = '0;
    err_total  = 0;
    n_compared = 0;
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    apb(1'b0, `FBDS_IDX_FB_CTRL, 32'h0);
    chk("control reset", rd, 32'h0);
    apb(1'b0, `FBDS_IDX_MON_SEL, 32'h0);
    chk("select reset", rd, 32'h0);
    chk("monitor reset", {31'h0, o_monitor_pin}, 32'h0);
    apb(1'b1, `FBDS_IDX_MON_SEL, 32'hFFFF_FFFF);
    apb(1'b0, `FBDS_IDX_MON_SEL, 32'h0);
    chk("select readback", rd, 32'h0000_00FF);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `FBDS_IDX_STATUS, 32'h1);
    chk("status write error", {31'h0, er}, 32'h1);
    apb(1'b1, `FBDS_IDX_MAIN_VAL, 32'h2);
    apb(1'b1, `FBDS_IDX_REF_VAL, 32'h5);
    apb(1'b0, `FBDS_IDX_MAIN_VAL, 32'h0);
    chk("main readback", rd, 32'h2);
    div(8'h00, 6'h01, `FBDS_MON_N, 6'h20, 65);
    div(8'h01, 6'h01, `FBDS_MON_N, 6'h20, 32);
    div(8'h07, 6'h01, `FBDS_MON_N, 6'h20, 21);
    div(8'h02, 6'h01, `FBDS_MON_N, 6'h20, 26);
    div(8'h02, 6'h00, `FBDS_MON_N, 6'h20, 32);
    div(8'h03, 6'h01, `FBDS_MON_N, 6'h20, 14);
    div(8'h04, 6'h01, `FBDS_MON_N, 6'h20, 7);
    div(8'h05, 6'h01, `FBDS_MON_N, 6'h20, 3);
    div(8'h06, 6'h01, `FBDS_MON_N, 6'h20, 2);
    div(8'h09, 6'h01, `FBDS_MON_N, 6'h20, 65);
    div(8'h0A, 6'h01, `FBDS_MON_N, 6'h20, 26);
    div(8'h20, 6'h01, `FBDS_MON_N, 6'h20, 0);
    div(8'h01, 6'h01, `FBDS_MON_PRE, 6'h20, 65);
    div(8'h02, 6'h01, `FBDS_MON_A, 6'h20, 26);
    div(8'h00, 6'h01, `FBDS_MON_R, 6'h10, 26);
    div(8'h40, 6'h01, `FBDS_MON_R, 6'h10, 0);
    div(8'h10, 6'h01, `FBDS_MON_R, 6'h10, 0);
    apb(1'b1, `FBDS_IDX_REF_CFG, 32'h2);
    div(8'h00, 6'h01, `FBDS_MON_R, 6'h08, 26);
    lvl(6'h00, 1'b0, 6'h3F, 1'b0);
    lvl(6'h07, 1'b0, 6'h3F, 1'b0);
    lvl(6'h1F, 1'b0, 6'h3F, 1'b0);
    lvl(6'h20, 1'b0, 6'h3F, 1'b0);
    lvl(6'h05, 1'b0, 6'h02, 1'b1);
    lvl(6'h05, 1'b0, 6'h3D, 1'b0);
    lvl(6'h06, 1'b0, 6'h01, 1'b1);
    lvl(6'h06, 1'b0, 6'h3E, 1'b0);
    lvl(6'h21, 1'b0, 6'h10, 1'b1);
    lvl(6'h21, 1'b0, 6'h2F, 1'b0);
    lvl(6'h21, 1'b1, 6'h04, 1'b1);
    lvl(6'h21, 1'b1, 6'h3B, 1'b0);
    lvl(6'h22, 1'b0, 6'h08, 1'b1);
    lvl(6'h22, 1'b0, 6'h37, 1'b0);
    lvl(6'h22, 1'b1, 6'h3F, 1'b0);
    apb(1'b1, `FBDS_IDX_MON_SEL, {24'h0, `FBDS_MON_UP, 2'h0});
    board.set_lvl(fbds_pkg::fbds_pins_t'(6'h02));
    repeat (8) @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    board.set_lvl(fbds_pkg::fbds_pins_t'(6'h00));
    repeat (8) @(posedge i_sys_clk);
    chk("frozen monitor", {31'h0, o_monitor_pin}, 32'h1);
    i_clk_en <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk("thawed monitor", {31'h0, o_monitor_pin}, 32'h0);
    finish_test();
  end
endmodule
